// ===== core/fsr_pkg.sv
// Purpose: Shared constants and types for the flash status register readout.
// Assumes: Serial mode 0 framing, most significant bit first.
// Notes: Bit positions refer to status byte one unless named otherwise.
package fsr_pkg;

    // Serial opcodes decoded by the status logic.
    localparam logic [7:0] FSR_OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] FSR_OPC_WRITE_STATUS = 8'h01;

    // Field positions within status byte one.
    localparam int FSR_BIT_LOCK = 7;
    localparam int FSR_BIT_SEQ = 6;
    localparam int FSR_BIT_ERR = 5;
    localparam int FSR_BIT_WPIN = 4;
    localparam int FSR_BIT_SWP_HI = 3;
    localparam int FSR_BIT_SWP_LO = 2;
    localparam int FSR_BIT_WEL = 1;
    localparam int FSR_BIT_BUSY = 0;

    // Field positions within status byte two.
    localparam int FSR_B2_BIT_RSTEN = 4;
    localparam int FSR_B2_BIT_BUSY = 0;

    // Field positions of the status write data byte.
    localparam int FSR_WD_LOCK = 7;
    localparam int FSR_WD_GP_HI = 5;
    localparam int FSR_WD_GP_LO = 2;

    // Reset values and counts.
    localparam logic FSR_LOCK_RST = 1'b0;
    localparam logic FSR_WEL_RST = 1'b0;
    localparam logic FSR_ERR_RST = 1'b0;
    localparam logic [1:0] FSR_SWP_RST = 2'h3;
    localparam logic [7:0] FSR_STATUS_RST = 8'h0C;
    localparam logic [3:0] FSR_OPC_LAST_BIT = 4'h7;
    localparam logic [3:0] FSR_DATA_BITS = 4'h8;

    // Protocol states of the serial front end.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_READ,
        ST_WRITE,
        ST_SKIP
    } fsr_state_type;

    // Synchronised pin levels.
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
        logic wp_n;
    } fsr_pins_type;

    // Whole state of the status block.
    typedef struct packed {
        fsr_state_type state;
        logic [3:0] bit_cnt;
        logic [3:0] pos;
        logic [7:0] shreg;
        logic sck_q;
        logic lock;
        logic err;
        logic write_enable_latch;
        logic [7:0] status;
        logic sdo;
        logic sdo_oe;
        logic allow;
        logic gp_valid;
        logic [3:0] gp_bits;
    } fsr_regs_type;

endpackage

// ===== core/fsr_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pin levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module fsr_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock_i, // System clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic ce_i, // Clock enable.
    input wire logic [WIDTH-1:0] async_i, // Levels from outside the domain.
    output logic [WIDTH-1:0] sync_o // Levels safe to use.
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Two stages of flip-flops, frozen with the clock enable.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else if (ce_i)
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // fsr_sync

// ===== core/fsr_status.sv
// Purpose: Status register logic of a serial flash: read and write of status.
// Assumes: Serial mode 0, pins sampled by clock_i, serial clock well below it.
// Notes: Flash engine signals arrive on clock_i and need no synchroniser.
`timescale 1ns/1ps
module fsr_status
    import fsr_pkg::*;
(
    input wire logic clock_i, // System clock, 200 MHz.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic ce_i, // Clock enable; low freezes all state.
    input wire logic cs_n_i, // Chip select pin, active low.
    input wire logic sck_i, // Serial clock pin.
    input wire logic sdi_i, // Serial data in pin.
    input wire logic wp_n_i, // Write protect pin, active low.
    input wire logic dev_reset_i, // Device reset pulse from the core.
    input wire logic busy_i, // Internal operation in progress.
    input wire logic seq_mode_i, // Sequential programming mode entered.
    input wire logic [1:0] prot_summary_i, // Sector protection summary.
    input wire logic reset_en_i, // Reset command enable for byte two.
    input wire logic op_done_i, // Pulse: erase or program finished.
    input wire logic op_fail_i, // With op_done_i: a byte failed.
    input wire logic op_abort_i, // With op_done_i: operation aborted.
    input wire logic wel_set_i, // Pulse: write enable command.
    input wire logic wel_clr_i, // Pulse: core clears write enable.
    output logic sdo_o, // Serial data out level.
    output logic sdo_oe_o, // Serial data out enable, high drives.
    output logic [7:0] status_o, // Status byte one, one cycle behind its sources; the pin bit lags wp_n_i by three.
    output logic lock_o, // Protection lock bit.
    output logic wel_o, // Write enable latch.
    output logic sector_allow_o, // Sector and global protect allowed.
    output logic gp_valid_o, // Pulse: global protect request.
    output logic [3:0] gp_bits_o // Global protect request bits.
);

    fsr_pins_type pins_raw;
    fsr_pins_type pins;
    fsr_regs_type s_r;
    fsr_regs_type s_nxt;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] byte_one;
    logic [7:0] byte_two;
    logic [15:0] word;
    logic [7:0] opc;
    logic new_lock;

    // Gather pin levels for the synchroniser.
    always_comb
    begin
        pins_raw.cs_n = cs_n_i;
        pins_raw.sck = sck_i;
        pins_raw.sdi = sdi_i;
        pins_raw.wp_n = wp_n_i;
    end

    // Pins cross into the clock domain through two flip-flops each.
    // All four pins share one delay, so data in keeps its place against the clock.
    // Reset levels match an idle link: deselected, clock low, protect pin released.
    fsr_sync #(
        .WIDTH(4),
        .RST_VAL(4'h9)
    ) fsr_sync_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    // Serial clock edges found from the synchronised level.
    // Each serial clock phase must span several system clocks, or edges are lost.
    assign sck_rise = pins.sck & ~s_r.sck_q;
    assign sck_fall = ~pins.sck & s_r.sck_q;

    // Live status bytes, rebuilt every cycle from current state.
    // Nothing is latched at opcode time, so a long read tracks every change.
    always_comb
    begin
        byte_one = 8'h00;
        byte_one[FSR_BIT_LOCK] = s_r.lock;
        byte_one[FSR_BIT_SEQ] = seq_mode_i;
        byte_one[FSR_BIT_ERR] = s_r.err;
        byte_one[FSR_BIT_WPIN] = pins.wp_n;
        byte_one[FSR_BIT_SWP_HI:FSR_BIT_SWP_LO] = prot_summary_i;
        byte_one[FSR_BIT_WEL] = s_r.write_enable_latch;
        byte_one[FSR_BIT_BUSY] = busy_i;
        // Byte two carries only the reset enable and a copy of busy.
        byte_two = 8'h00;
        byte_two[FSR_B2_BIT_RSTEN] = reset_en_i;
        byte_two[FSR_B2_BIT_BUSY] = busy_i;
        word = {byte_one, byte_two};
    end

    // Opcode as it stands once the last opcode bit is shifted in.
    assign opc = {s_r.shreg[6:0], pins.sdi};

    // Lock value a status write would produce, honouring the pin.
    // An asserted pin lets the lock rise but never fall.
    always_comb
    begin
        if (!pins.wp_n)
        begin
            new_lock = s_r.lock | s_r.shreg[FSR_WD_LOCK];
        end
        else
        begin
            new_lock = s_r.shreg[FSR_WD_LOCK];
        end
    end

    // Next state of the whole block.
    // Fields not touched below keep their value, so each branch names only changes.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sck_q = pins.sck;
        s_nxt.gp_valid = 1'b0;
        s_nxt.status = byte_one;
        // The protection gate lags the lock by one cycle, like the lock bit of status_o.
        s_nxt.allow = ~s_r.lock;

        // Error flag rewritten at the end of each operation; aborts leave it low.
        // A failure that arrives with an abort is treated as an abort.
        if (op_done_i)
        begin
            s_nxt.err = op_fail_i & ~op_abort_i;
        end

        // Write enable latch: a set arriving with a clear wins.
        // The clear is applied first so that the later set overrides it.
        if (wel_clr_i)
        begin
            s_nxt.write_enable_latch = 1'b0;
        end
        if (wel_set_i)
        begin
            s_nxt.write_enable_latch = 1'b1;
        end

        case (s_r.state)
            ST_IDLE:
            begin
                // The output stays released until an opcode has been decoded.
                s_nxt.sdo_oe = 1'b0;
                if (!pins.cs_n)
                begin
                    s_nxt.state = ST_OPCODE;
                    s_nxt.bit_cnt = 4'h0;
                end
            end
            ST_OPCODE:
            begin
                // Opcode bits sampled on rising serial clock.
                // Data in passes the same synchroniser, so it is settled at that edge.
                if (sck_rise)
                begin
                    s_nxt.shreg = opc;
                    s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    if (s_r.bit_cnt == FSR_OPC_LAST_BIT)
                    begin
                        // The counter is reused for the data byte of a status write.
                        s_nxt.bit_cnt = 4'h0;
                        if (opc == FSR_OPC_READ_STATUS)
                        begin
                            // Accepted regardless of busy.
                            s_nxt.state = ST_READ;
                            s_nxt.pos = 4'h0;
                        end
                        else if (opc == FSR_OPC_WRITE_STATUS)
                        begin
                            s_nxt.state = ST_WRITE;
                        end
                        else
                        begin
                            s_nxt.state = ST_SKIP;
                        end
                    end
                end
            end
            ST_READ:
            begin
                // One bit per falling clock, top bit first, wrapping.
                // The bit shows on the third system clock edge after the pin edge.
                // The host must sample no earlier than its next rising edge.
                if (sck_fall)
                begin
                    s_nxt.sdo = word[~s_r.pos];
                    s_nxt.sdo_oe = 1'b1;
                    s_nxt.pos = s_r.pos + 4'h1;
                end
            end
            ST_WRITE:
            begin
                // One data byte kept; further bytes are ignored.
                // Counting stops at eight, so a longer frame still applies.
                if (sck_rise && (s_r.bit_cnt != FSR_DATA_BITS))
                begin
                    s_nxt.shreg = opc;
                    s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                end
            end
            ST_SKIP:
            begin
                // Unknown opcodes wait here for release without touching the latch.
                s_nxt.sdo_oe = 1'b0;
            end
            default:
            begin
                // Unused codes of the state type fall back to idle.
                s_nxt.state = ST_IDLE;
            end
        endcase

        // Release of chip select ends any command at any bit.
        // It is checked after the case so that it overrides every state.
        if (pins.cs_n && (s_r.state != ST_IDLE))
        begin
            s_nxt.state = ST_IDLE;
            s_nxt.sdo_oe = 1'b0;
            if (s_r.state == ST_WRITE)
            begin
                // The lock bit and the global protect bits are taken from the data byte.
                // A short data byte aborts: lock kept and no protect request.
                if (s_r.write_enable_latch && (s_r.bit_cnt == FSR_DATA_BITS))
                begin
                    s_nxt.lock = new_lock;
                    s_nxt.gp_bits = s_r.shreg[FSR_WD_GP_HI:FSR_WD_GP_LO];
                    s_nxt.gp_valid = ~s_r.lock;
                end
                // Latch drops whether the write completes or aborts, unless a set arrives in that cycle.
                s_nxt.write_enable_latch = wel_set_i;
            end
        end

        // Device reset returns lock and latch to their defaults.
        // It stands last so that it beats a status write in the same cycle.
        if (dev_reset_i)
        begin
            s_nxt.lock = FSR_LOCK_RST;
            s_nxt.write_enable_latch = FSR_WEL_RST;
        end
    end

    // State register, frozen when the clock enable is low.
    // Freezing the edge detector with the rest keeps edges consistent across pauses.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r.state <= ST_IDLE;
            s_r.bit_cnt <= 4'h0;
            s_r.pos <= 4'h0;
            s_r.shreg <= 8'h00;
            s_r.sck_q <= 1'b0;
            s_r.lock <= FSR_LOCK_RST;
            s_r.err <= FSR_ERR_RST;
            s_r.write_enable_latch <= FSR_WEL_RST;
            s_r.status <= FSR_STATUS_RST;
            s_r.sdo <= 1'b0;
            s_r.sdo_oe <= 1'b0;
            s_r.allow <= 1'b1;
            s_r.gp_valid <= 1'b0;
            s_r.gp_bits <= 4'h0;
        end
        else if (ce_i)
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    // No output is decoded combinationally, so none can glitch.
    assign sdo_o = s_r.sdo;
    assign sdo_oe_o = s_r.sdo_oe;
    assign status_o = s_r.status;
    assign lock_o = s_r.lock;
    assign wel_o = s_r.write_enable_latch;
    assign sector_allow_o = s_r.allow;
    assign gp_valid_o = s_r.gp_valid;
    assign gp_bits_o = s_r.gp_bits;

endmodule // fsr_status

// ===== bench/fsr_host_model.sv
// Purpose: Serial host model that frames status reads and writes.
// Assumes: Mode 0 framing, link clock period 48 ns, clock idle low outside frames.
// Notes: Data in shows the inverse of its last bit while deselected.
`timescale 1ns/1ps
module fsr_host_model (
    output logic cs_n_o, // Chip select, active low.
    output logic sck_o, // Serial clock.
    output logic sdi_o, // Serial data to the device.
    input wire logic so_i // Resolved serial data line.
);
    // Idle levels before the first frame.
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Opcode, then n clocks of data; reply sampled late in each high phase.
    task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int n,
        output logic [39:0] rx);
        logic [7:0] tx;
        rx = '0;
        #1.2; // Keeps every pin change off the system clock edges.
        cs_n_o = 1'b0;
        #30;
        for (int j = 0; j < 8 + n; j++)
        begin
            tx = (j < 8) ? op : wd;
            sdi_o = tx[7 - j % 8];
            #24 sck_o = 1'b1;
            #24 rx = (j >= 8) ? {rx[38:0], so_i} : rx;
            sck_o = 1'b0;
        end
        #24 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask
endmodule // fsr_host_model

// ===== bench/fsr_status_properties.sv
// Purpose: Concurrent checks on the status block ports.
// Assumes: One clock domain, status_o one cycle behind its sources, three behind the protect pin.
// Notes: Bound to every instance of the status block.
`timescale 1ns/1ps
module fsr_status_checker
    import fsr_pkg::*;
(
    input wire logic clock_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic cs_n_i, // Select.
    input wire logic wp_n_i, // Protect pin.
    input wire logic dev_reset_i, // Core reset.
    input wire logic busy_i, // Busy.
    input wire logic [1:0] prot_summary_i, // Protection.
    input wire logic op_done_i, // Done.
    input wire logic op_fail_i, // Fail.
    input wire logic op_abort_i, // Abort.
    input wire logic sdo_oe_o, // Out enable.
    input wire logic [7:0] status_o, // Status.
    input wire logic lock_o, // Lock.
    input wire logic wel_o, // Latch.
    input wire logic sector_allow_o // Allow.
);
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // Live fields follow their sources.
    busy_live_a: assert property (status_o[FSR_BIT_BUSY] == $past(busy_i))
        else $error("busy bit lags");
    swp_live_a: assert property (status_o[3:2] == $past(prot_summary_i))
        else $error("protection summary wrong");
    wpin_rise_a: assert property ($rose(wp_n_i) |-> ##[2:6] status_o[FSR_BIT_WPIN])
        else $error("pin bit stuck");
    lock_shown_a: assert property ($stable(lock_o) |-> status_o[FSR_BIT_LOCK] == lock_o)
        else $error("lock bit not shown");
    // Error flag after each operation end.
    err_set_a: assert property (op_done_i && op_fail_i && !op_abort_i |-> ##2 status_o[5])
        else $error("error flag not set");
    err_abort_a: assert property (op_done_i && op_abort_i |-> ##2 !status_o[5])
        else $error("error flag set on abort");
    // Output release and protection gating.
    so_float_a: assert property (cs_n_i [*6] |-> !sdo_oe_o)
        else $error("output still driven");
    allow_lock_a: assert property (sector_allow_o == !$past(lock_o))
        else $error("allow does not match lock");
    dev_reset_a: assert property (dev_reset_i |=> !lock_o && !wel_o)
        else $error("reset left lock or latch");
    lock_hold_a: assert property ((!wp_n_i) [*6] ##1 (lock_o && !wp_n_i && !dev_reset_i)
        |=> lock_o)
        else $error("lock fell while pin asserted");
endmodule // fsr_status_checker
bind fsr_status fsr_status_checker fsr_status_checker_inst (.*);

// ===== bench/tb_fsr_status.sv
// Purpose: Self-checking bench for the status block with a serial host model.
// Assumes: Seed 18, host link clock 48 ns, core signals driven on clock edges.
// Notes: Expected stream is rebuilt from the inputs and the bench lock model.
`timescale 1ns/1ps
module tb_fsr_status;
    import fsr_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i, ce_i, cs_n_i, sck_i, sdi_i, wp_n_i, dev_reset_i, busy_i, seq_mode_i;
    logic reset_en_i, op_done_i, op_fail_i, op_abort_i, wel_set_i, wel_clr_i;
    logic [1:0] prot_summary_i;
    logic sdo_o, sdo_oe_o, lock_o, wel_o, sector_allow_o, gp_valid_o;
    logic [7:0] status_o;
    logic [3:0] gp_bits_o, gp_seen;
    logic exp_lock = 1'b0, exp_wel = 1'b0, exp_err = 1'b0;
    logic [39:0] rx;
    logic [9:0] wtab [5] = '{10'h3BC, 10'h200, 10'h000, 10'h300, 10'h3A4};
    logic [1:0] etab [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    int errors = 0, check_count = 0, gp_count = 0, exp_gp = 0;
    wire so_line;
    // The data line floats while the device is not driving it.
    assign so_line = sdo_oe_o ? sdo_o : 1'bz;
    always #2.5 clock_i = ~clock_i;
    fsr_status fsr_status_inst (.*);
    fsr_host_model host (.cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i), .so_i(so_line));
    // Count protect requests and keep the last bits.
    always @(posedge clock_i)
    begin
        if (gp_valid_o === 1'b1)
        begin
            gp_count++;
            gp_seen = gp_bits_o;
        end
    end
    function automatic logic [7:0] exp_b1();
        return {exp_lock, seq_mode_i, exp_err, wp_n_i, prot_summary_i, exp_wel, busy_i};
    endfunction
    function automatic logic [39:0] exp_stream(input int n);
        logic [15:0] w;
        logic [39:0] s;
        w = {exp_b1(), 3'h0, reset_en_i, 3'h0, busy_i};
        s = '0;
        for (int i = 0; i < n; i++)
            s = {s[38:0], w[15 - i % 16]};
        return s;
    endfunction
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic read_check(input int n);
        host.frame(FSR_OPC_READ_STATUS, 8'($urandom), n, rx);
        check("stream", rx, exp_stream(n));
        repeat (8) @(posedge clock_i);
        check("so_float", sdo_oe_o, 1'b0);
        check("status", status_o, exp_b1());
    endtask
    // Watchdog against a hung sequence.
    initial
    begin
        #300us;
        errors++;
        complete_run();
    end
    // Main sequence.
    initial
    begin
        {rst_i, ce_i, wp_n_i, prot_summary_i} = 5'h1F;
        {dev_reset_i, busy_i, seq_mode_i, reset_en_i, op_done_i} = 5'h00;
        {op_fail_i, op_abort_i, wel_set_i, wel_clr_i} = 4'h0;
        void'($urandom(18));
        repeat (3) @(posedge clock_i);
        check("rst_status", status_o, 8'h0C);
        check("rst_lock", {lock_o, wel_o, sector_allow_o}, 3'h1);
        rst_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        for (int k = 0; k < 5; k++)
        begin
            {busy_i, seq_mode_i, prot_summary_i, wp_n_i, reset_en_i} <= 6'($urandom);
            repeat (8) @(posedge clock_i);
            read_check(k == 0 ? 5 : 40);
        end
        foreach (etab[i])
        begin
            {op_done_i, op_fail_i, op_abort_i} <= {1'b1, etab[i]};
            @(posedge clock_i);
            op_done_i <= 1'b0;
            exp_err = etab[i][1] & ~etab[i][0];
            repeat (3) @(posedge clock_i);
            check("err", status_o[FSR_BIT_ERR], exp_err);
        end
        foreach (wtab[i])
        begin
            wp_n_i <= wtab[i][8];
            wel_set_i <= wtab[i][9];
            @(posedge clock_i);
            wel_set_i <= 1'b0;
            exp_wel = wtab[i][9];
            repeat (6) @(posedge clock_i);
            check("wel", wel_o, exp_wel);
            exp_gp += (exp_wel && !exp_lock) ? 1 : 0;
            exp_lock = !exp_wel ? exp_lock : wtab[i][8] ? wtab[i][7] : exp_lock | wtab[i][7];
            exp_wel = 1'b0;
            host.frame(FSR_OPC_WRITE_STATUS, wtab[i][7:0], 8, rx);
            repeat (8) @(posedge clock_i);
            check("lock", {lock_o, wel_o, sector_allow_o}, {exp_lock, 1'b0, !exp_lock});
            check("gp", gp_count, exp_gp);
            read_check(24);
        end
        check("gp_bits", gp_seen, 4'h9);
        // Clock enable low: a latch pulse meanwhile is not taken.
        {ce_i, wel_set_i} <= 2'h1;
        @(posedge clock_i);
        {ce_i, wel_set_i} <= 2'h2;
        @(posedge clock_i);
        check("ce_hold", wel_o, 1'b0);
        // Set and clear together: the set wins; a clear alone drops the latch.
        {wel_set_i, wel_clr_i} <= 2'h3;
        @(posedge clock_i);
        {wel_set_i, wel_clr_i} <= 2'h1;
        @(posedge clock_i);
        check("wel_both", wel_o, 1'b1);
        wel_clr_i <= 1'b0;
        @(posedge clock_i);
        check("wel_clr", wel_o, 1'b0);
        // Device reset with a latch set in the same cycle: reset wins for both.
        {dev_reset_i, wel_set_i} <= 2'h3;
        @(posedge clock_i);
        {dev_reset_i, wel_set_i} <= 2'h0;
        exp_lock = 1'b0;
        read_check(16);
        complete_run();
    end
endmodule // tb_fsr_status
